// >>> rtl/system_control_registers.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module system_control_registers #(
    parameter logic [31:0] CHIP_ID = sysctl_pkg::ID_DEFAULT
) (
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire sysctl_pkg::bus_req_t      bus,
    output logic [31:0]                    rdata,
    input  wire logic                      boot_select_pin_a,
    input  wire logic                      boot_select_pin_b,
    input  wire sysctl_pkg::cause_in_t     cause_in,
    input  wire logic                      extlogic_reset_req,
    input  wire logic                      pll_locked,
    input  wire logic                      xtal_stable,
    input  wire logic [7:0]                external_interrupt_lines,
    input  wire logic                      rtc_alarm,
    input  wire logic                      core_halted,
    output logic                           reset_request,
    output logic [1:0]                     sleep_depth_select,
    output sysctl_pkg::clk_ctl_t           clk_ctl,
    output logic [4:0]                     debug_pin_release,
    output logic                           freeze_calendar,
    output logic                           freeze_indep_dog,
    output logic [8:0]                     wake_event_pending,
    output logic [28:0]                    slow_unit_reset,
    output logic [3:0]                     fast_unit_reset,
    output logic [28:0]                    slow_unit_clock_en,
    output logic [3:0]                     fast_unit_clock_en
);
    import sysctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    logic [1:0]  boot_s1_reg;
    logic [1:0]  boot_s2_reg;
    logic [5:0]  cause_s1_reg;
    logic [5:0]  cause_s2_reg;
    logic [2:0]  misc_s1_reg;
    logic [2:0]  misc_s2_reg;
    logic [8:0]  wake_s1_reg;
    logic [8:0]  wake_s2_reg;
    logic [8:0]  wake_prev_reg;
    logic [2:0]  boot_count_reg;
    logic [1:0]  boot_mode_reg;
    logic [6:0]  cause_reg;
    logic        ext_allow_reg;
    logic [1:0]  depth_reg;
    logic [3:0]  div_high_reg;
    logic [3:0]  div_low_reg;
    logic [2:0]  osc_reg;
    logic [4:0]  dpin_reg;
    logic [1:0]  frz_reg;
    logic [8:0]  wrise_reg;
    logic [8:0]  wfall_reg;
    logic [8:0]  wpend_reg;
    logic [3:0]  pdiv_reg;
    logic [28:0] srst_reg;
    logic [3:0]  frst_reg;
    logic [28:0] sclk_reg;
    logic [3:0]  fclk_reg;
    logic [28:0] halt_reg;
    logic        halt_s1_reg;
    logic        halt_s2_reg;
    logic [31:0] rdata_next;
    logic        wr_rst;
    logic [8:0]  wake_hit;

    // Two flip-flops on every input coming from outside the clock domain.
    always_ff @(posedge sys_clk) begin
        boot_s1_reg  <= {boot_select_pin_b, boot_select_pin_a};
        boot_s2_reg  <= boot_s1_reg;
        cause_s1_reg <= cause_in;
        cause_s2_reg <= cause_s1_reg;
        misc_s1_reg  <= {extlogic_reset_req, pll_locked, xtal_stable};
        misc_s2_reg  <= misc_s1_reg;
        wake_s1_reg  <= {rtc_alarm, external_interrupt_lines};
        wake_s2_reg  <= wake_s1_reg;
        halt_s1_reg  <= core_halted;
        halt_s2_reg  <= halt_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boot mode capture.

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boot_count_reg <= 3'h0;
            boot_mode_reg  <= 2'h0;
        end else if (boot_count_reg != BOOT_EDGE) begin
            boot_count_reg <= boot_count_reg + 3'h1;
            if (boot_count_reg == BOOT_EDGE - 3'h1) begin
                boot_mode_reg <= boot_s2_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset causes and requests.

    assign wr_rst = bus.wr && (bus.addr == OFS_RST);

    // flags survive reset
    // Flags are not cleared by system reset; power-on sets its own flag and
    // clears the rest, and a new cause wins over a simultaneous clear.
    always_ff @(posedge sys_clk) begin
        if (cause_s2_reg[2]) begin
            cause_reg <= 7'h04;
        end else begin
            cause_reg <= (wr_rst && bus.wdata[BIT_CAUSE_CLR]) ? 7'h00 : cause_reg;
            if (cause_s2_reg[5]) cause_reg[6] <= 1'b1;
            if (cause_s2_reg[4]) cause_reg[5] <= 1'b1;
            if (cause_s2_reg[3]) cause_reg[4] <= 1'b1;
            if (wr_rst && bus.wdata[BIT_SW_TRIG]) cause_reg[3] <= 1'b1;
            if (cause_s2_reg[1]) cause_reg[1] <= 1'b1;
            if (cause_s2_reg[0] || (ext_allow_reg && misc_s2_reg[2])) cause_reg[0] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_allow_reg <= 1'b0;
            reset_request <= 1'b0;
        end else begin
            if (wr_rst) ext_allow_reg <= bus.wdata[BIT_EXT_ALLOW];
            reset_request <= (wr_rst && bus.wdata[BIT_SW_TRIG]) || (ext_allow_reg && misc_s2_reg[2]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers written by software.

    // Read-write fields; the halt field keeps only the HALT_MASK bits.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            depth_reg    <= 2'h0;
            div_high_reg <= 4'h0;
            div_low_reg  <= 4'h0;
            osc_reg      <= 3'h0;
            dpin_reg     <= 5'h00;
            frz_reg      <= 2'h0;
            wrise_reg    <= 9'h000;
            wfall_reg    <= 9'h000;
            pdiv_reg     <= 4'h0;
            srst_reg     <= 29'h0000_0000;
            frst_reg     <= 4'h0;
            sclk_reg     <= 29'h0000_0000;
            fclk_reg     <= 4'h0;
            halt_reg     <= 29'h0000_0000;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_PWR: depth_reg <= bus.wdata[1:0];
                OFS_CLK: begin
                    div_high_reg <= bus.wdata[POS_DIV_HIGH +: 4];
                    div_low_reg  <= bus.wdata[POS_DIV_LOW +: 4];
                    osc_reg      <= {bus.wdata[BIT_PLL_ON], bus.wdata[BIT_XTAL_BYP], bus.wdata[BIT_XTAL_ON]};
                end
                OFS_DPIN: dpin_reg <= bus.wdata[4:0];
                OFS_DBG: frz_reg <= {bus.wdata[BIT_FRZ_CAL], bus.wdata[BIT_FRZ_DOG]};
                OFS_WRISE: wrise_reg <= bus.wdata[8:0];
                OFS_WFALL: wfall_reg <= bus.wdata[8:0];
                OFS_PDIV: pdiv_reg <= bus.wdata[3:0];
                OFS_SRST: srst_reg <= bus.wdata[28:0];
                OFS_FRST: frst_reg <= bus.wdata[3:0];
                OFS_SCLK: sclk_reg <= bus.wdata[28:0];
                OFS_FCLK: fclk_reg <= bus.wdata[3:0];
                OFS_HALT: halt_reg <= bus.wdata[28:0] & HALT_MASK;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake events.

    assign wake_hit = (wrise_reg & wake_s2_reg & ~wake_prev_reg)
                    | (wfall_reg & ~wake_s2_reg & wake_prev_reg);

    // write one clears
    // A new event in the clear cycle keeps its bit set.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wake_prev_reg <= 9'h000;
            wpend_reg     <= 9'h000;
        end else begin
            wake_prev_reg <= wake_s2_reg;
            wpend_reg     <= (wpend_reg & ~((bus.wr && bus.addr == OFS_WPEND) ? bus.wdata[8:0] : 9'h000))
                           | wake_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered.

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sleep_depth_select <= MODE_SLEEP;
            clk_ctl            <= '0;
            debug_pin_release  <= 5'h00;
            freeze_calendar    <= 1'b0;
            freeze_indep_dog   <= 1'b0;
            wake_event_pending <= 9'h000;
            slow_unit_reset    <= 29'h0000_0000;
            fast_unit_reset    <= 4'h0;
            slow_unit_clock_en <= 29'h0000_0000;
            fast_unit_clock_en <= 4'h0;
        end else begin
            sleep_depth_select     <= depth_reg;
            clk_ctl.pll_on         <= osc_reg[2];
            clk_ctl.xtal_bypass    <= osc_reg[1];
            clk_ctl.xtal_power     <= osc_reg[0];
            clk_ctl.flash_div      <= div_high_reg;
            clk_ctl.periph_bus_div <= pdiv_reg;
            debug_pin_release      <= dpin_reg;
            freeze_calendar        <= frz_reg[1] && halt_s2_reg;
            freeze_indep_dog       <= frz_reg[0] && halt_s2_reg;
            wake_event_pending     <= wpend_reg;
            slow_unit_reset        <= srst_reg;
            fast_unit_reset        <= frst_reg;
            // Halt bits gate clocks only while the core sits in debug.
            slow_unit_clock_en     <= sclk_reg & ~(halt_s2_reg ? halt_reg : 29'h0000_0000);
            fast_unit_clock_en     <= fclk_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe.

    always_comb begin
        rdata_next = ZERO_WORD;
        case (bus.addr)
            OFS_BOOT:  rdata_next[1:0] = boot_mode_reg;
            OFS_RST:   rdata_next = {cause_reg, 1'b0, 22'h00_0000, ext_allow_reg, 1'b0};
            OFS_PWR:   rdata_next[1:0] = depth_reg;
            OFS_CLK:   rdata_next[15:0] = {div_high_reg, div_low_reg, 1'b0, misc_s2_reg[1], osc_reg[2],
                                           misc_s2_reg[0], osc_reg[1], osc_reg[0], 2'b00};
            OFS_DPIN:  rdata_next[4:0] = dpin_reg;
            OFS_DBG:   rdata_next[4:3] = frz_reg;
            OFS_WRISE: rdata_next[8:0] = wrise_reg;
            OFS_WFALL: rdata_next[8:0] = wfall_reg;
            OFS_WPEND: rdata_next[8:0] = wpend_reg;
            OFS_PDIV:  rdata_next[3:0] = pdiv_reg;
            OFS_SRST:  rdata_next[28:0] = srst_reg;
            OFS_FRST:  rdata_next[3:0] = frst_reg;
            OFS_SCLK:  rdata_next[28:0] = sclk_reg;
            OFS_FCLK:  rdata_next[3:0] = fclk_reg;
            OFS_HALT:  rdata_next[28:0] = halt_reg;
            OFS_ID:    rdata_next = CHIP_ID;
            default:   rdata_next = ZERO_WORD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata <= ZERO_WORD;
        end else begin
            rdata <= bus.rd ? rdata_next : ZERO_WORD;
        end
    end

endmodule

// >>> rtl/sysctl_pkg.sv
package sysctl_pkg;

    // Register byte offsets.
    localparam logic [11:0] OFS_BOOT      = 12'h000;
    localparam logic [11:0] OFS_RST       = 12'h004;
    localparam logic [11:0] OFS_PWR       = 12'h008;
    localparam logic [11:0] OFS_CLK       = 12'h00c;
    localparam logic [11:0] OFS_DPIN      = 12'h014;
    localparam logic [11:0] OFS_DBG       = 12'h01c;
    localparam logic [11:0] OFS_WRISE     = 12'h020;
    localparam logic [11:0] OFS_WFALL     = 12'h024;
    localparam logic [11:0] OFS_WPEND     = 12'h028;
    localparam logic [11:0] OFS_PDIV      = 12'h038;
    localparam logic [11:0] OFS_SRST      = 12'h040;
    localparam logic [11:0] OFS_FRST      = 12'h050;
    localparam logic [11:0] OFS_SCLK      = 12'h060;
    localparam logic [11:0] OFS_FCLK      = 12'h070;
    localparam logic [11:0] OFS_HALT      = 12'h080;
    localparam logic [11:0] OFS_ID        = 12'h100;

    // Field positions in the reset cause and request register.
    localparam int BIT_CAUSE_LP   = 31;
    localparam int BIT_CAUSE_WWD  = 30;
    localparam int BIT_CAUSE_IWD  = 29;
    localparam int BIT_CAUSE_SW   = 28;
    localparam int BIT_CAUSE_POR  = 27;
    localparam int BIT_CAUSE_PIN  = 26;
    localparam int BIT_CAUSE_EXT  = 25;
    localparam int BIT_CAUSE_CLR  = 24;
    localparam int BIT_EXT_ALLOW  = 1;
    localparam int BIT_SW_TRIG    = 0;

    // Field positions in the oscillator, PLL and flash clock register.
    localparam int BIT_PLL_RDY    = 6;
    localparam int BIT_PLL_ON     = 5;
    localparam int BIT_XTAL_RDY   = 4;
    localparam int BIT_XTAL_BYP   = 3;
    localparam int BIT_XTAL_ON    = 2;
    localparam int POS_DIV_HIGH   = 12;
    localparam int POS_DIV_LOW    = 8;

    // Field positions in the debug freeze register.
    localparam int BIT_FRZ_CAL    = 4;
    localparam int BIT_FRZ_DOG    = 3;

    // Widths.
    localparam int SLOW_UNITS     = 29;
    localparam int FAST_UNITS     = 4;
    localparam int WAKE_SRCS      = 9;

    // Halt-capable units: watchdog 1, timers 15:14, general timers 20:16, CAN 26.
    localparam logic [28:0] HALT_MASK = 29'h041f_c002;

    // Reset values and timing.
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [2:0]  BOOT_EDGE     = 3'h4;
    localparam logic [31:0] ID_DEFAULT    = 32'h1234_5678;   // Arbitrary value.

    // Low-power mode encodings.
    typedef enum logic [1:0] {
        MODE_SLEEP   = 2'b00,
        MODE_STOP    = 2'b01,
        MODE_RSVD    = 2'b10,
        MODE_STANDBY = 2'b11
    } sleep_depth_t;

    // Register access port.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // Reset cause inputs, one cycle pulses or levels from the reset logic.
    typedef struct packed {
        logic lowpower;
        logic window_dog;
        logic indep_dog;
        logic poweron;
        logic pin;
        logic extlogic;
    } cause_in_t;

    // Clock control outputs.
    typedef struct packed {
        logic       pll_on;
        logic       xtal_power;
        logic       xtal_bypass;
        logic [3:0] flash_div;
        logic [3:0] periph_bus_div;
    } clk_ctl_t;

endpackage

// >>> tb/system_control_registers_props.sv
`timescale 1ns/1ps
module system_control_registers_props #(
    parameter logic [31:0] CHIP_ID = sysctl_pkg::ID_DEFAULT
) (
    input wire logic                 sys_clk,
    input wire logic                 reset,
    input wire sysctl_pkg::bus_req_t bus,
    input wire logic [31:0]          rdata,
    input wire logic                 core_halted,
    input wire logic                 reset_request,
    input wire logic [1:0]           sleep_depth_select,
    input wire sysctl_pkg::clk_ctl_t clk_ctl,
    input wire logic [4:0]           debug_pin_release,
    input wire logic                 freeze_calendar,
    input wire logic                 freeze_indep_dog,
    input wire logic [8:0]           wake_event_pending,
    input wire logic [28:0]          slow_unit_reset,
    input wire logic [3:0]           fast_unit_reset,
    input wire logic [3:0]           fast_unit_clock_en
);
    import sysctl_pkg::*;

    // All checks run on the system clock and rest while reset is high.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_id_read: assert property (bus.rd && bus.addr == OFS_ID |=> rdata == CHIP_ID)
        else $error("identifier read wrong");
    a_rdata_idle: assert property (!bus.rd |=> rdata == ZERO_WORD)
        else $error("read data not zero when idle");
    a_soft_trigger: assert property (bus.wr && bus.addr == OFS_RST && bus.wdata[BIT_SW_TRIG] |-> ##[1:2] reset_request)
        else $error("software reset not requested");
    a_sleep_field: assert property (bus.wr && bus.addr == OFS_PWR |-> ##2 sleep_depth_select == $past(bus.wdata[1:0], 2))
        else $error("sleep depth wrong");
    a_clock_fields: assert property (bus.wr && bus.addr == OFS_CLK |-> ##2
        clk_ctl[10:4] == {$past(bus.wdata[5], 2), $past(bus.wdata[2], 2), $past(bus.wdata[3], 2), $past(bus.wdata[15:12], 2)})
        else $error("clock control outputs wrong");
    a_periph_div: assert property (bus.wr && bus.addr == OFS_PDIV |-> ##2 clk_ctl.periph_bus_div == $past(bus.wdata[3:0], 2))
        else $error("bus divider wrong");
    a_pin_release: assert property (bus.wr && bus.addr == OFS_DPIN |-> ##2 debug_pin_release == $past(bus.wdata[4:0], 2))
        else $error("pin release wrong");
    a_slow_reset: assert property (bus.wr && bus.addr == OFS_SRST |-> ##2 slow_unit_reset == $past(bus.wdata[28:0], 2))
        else $error("slow unit reset wrong");
    a_fast_reset: assert property (bus.wr && bus.addr == OFS_FRST |-> ##2 fast_unit_reset == $past(bus.wdata[3:0], 2))
        else $error("fast unit reset wrong");
    a_fast_gate: assert property (bus.wr && bus.addr == OFS_FCLK |-> ##2 fast_unit_clock_en == $past(bus.wdata[3:0], 2))
        else $error("fast clock enable wrong");
    a_freeze_idle: assert property (!core_halted [*4] |-> !freeze_calendar && !freeze_indep_dog)
        else $error("freeze while running");
    a_reset_zero: assert property ($past(reset) |-> !reset_request && slow_unit_reset == '0 && wake_event_pending == '0)
        else $error("outputs not cleared by reset");
endmodule

bind system_control_registers system_control_registers_props #(.CHIP_ID(CHIP_ID)) u_props (
    .sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata), .core_halted(core_halted),
    .reset_request(reset_request), .sleep_depth_select(sleep_depth_select), .clk_ctl(clk_ctl),
    .debug_pin_release(debug_pin_release), .freeze_calendar(freeze_calendar), .freeze_indep_dog(freeze_indep_dog),
    .wake_event_pending(wake_event_pending), .slow_unit_reset(slow_unit_reset), .fast_unit_reset(fast_unit_reset),
    .fast_unit_clock_en(fast_unit_clock_en)
);

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    import sysctl_pkg::*;
    localparam logic [31:0] TB_ID = 32'h0a5c_3e71;   // Arbitrary value.
    localparam logic [11:0] ADR [14] = '{OFS_PWR, OFS_CLK, OFS_DPIN, OFS_DBG, OFS_WRISE, OFS_WFALL, OFS_PDIV,
        OFS_SRST, OFS_FRST, OFS_SCLK, OFS_FCLK, OFS_HALT, OFS_ID, 12'h0c0};
    localparam logic [31:0] MSK [14] = '{32'h3, 32'hff2c, 32'h1f, 32'h18, 32'h1ff, 32'h1ff, 32'hf,
        32'h1fff_ffff, 32'hf, 32'h1fff_ffff, 32'hf, 32'h041f_c002, 32'h0, 32'h0};
    localparam logic [31:0] ADD [14] = '{0, 32'h40, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, TB_ID, 0};
    logic        sys_clk, reset, pin_a, pin_b, ext_req, halted, alarm, req, frz_c, frz_d;
    bus_req_t    bus;
    cause_in_t   cause;
    clk_ctl_t    clk_ctl;
    logic [7:0]  lines;
    logic [31:0] rdata;
    logic [1:0]  depth;
    logic [4:0]  pins;
    logic [8:0]  pend;
    logic [28:0] srst, sclk;
    logic [3:0]  frst, fclk;
    int          fails, n_checks, req_cnt, i;

    system_control_registers #(.CHIP_ID(TB_ID)) uut (
        .sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata), .boot_select_pin_a(pin_a),
        .boot_select_pin_b(pin_b), .cause_in(cause), .extlogic_reset_req(ext_req), .pll_locked(1'b1),
        .xtal_stable(1'b0), .external_interrupt_lines(lines), .rtc_alarm(alarm), .core_halted(halted),
        .reset_request(req), .sleep_depth_select(depth), .clk_ctl(clk_ctl), .debug_pin_release(pins),
        .freeze_calendar(frz_c), .freeze_indep_dog(frz_d), .wake_event_pending(pend), .slow_unit_reset(srst),
        .fast_unit_reset(frst), .slow_unit_clock_en(sclk), .fast_unit_clock_en(fclk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, request counter and bus tasks.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (req === 1'b1) begin
            req_cnt++;
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(negedge sys_clk);
        `CHK($sformatf("reg %0h", a), e, rdata)
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #500_000;
        fails++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        {reset, pin_a, pin_b, ext_req, halted, alarm} = 6'b110000;
        {bus, cause, lines} = '0;
        {fails, n_checks, req_cnt} = '0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        `CHK("reset outs", 1'b0, |{req, srst, pend, depth})
        // Boot pins stay put; the latch fires on the fourth edge after release.
        repeat (4) @(posedge sys_clk);
        rd(OFS_BOOT, 32'h1);
        $display("test boot done");
        cause <= 6'b000100;
        repeat (3) @(posedge sys_clk);
        cause <= 6'b111011;
        repeat (3) @(posedge sys_clk);
        cause <= '0;
        repeat (4) @(posedge sys_clk);
        rd(OFS_RST, 32'hee00_0000);
        wr(OFS_RST, 32'h0100_0000);
        rd(OFS_RST, 32'h0);
        wr(OFS_RST, 32'h1);
        rd(OFS_RST, 32'h1000_0000);
        `CHK("soft req", 1, req_cnt)
        ext_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        `CHK("ext blocked", 1, req_cnt)
        ext_req <= 1'b0;
        wr(OFS_RST, 32'h2);
        ext_req <= 1'b1;
        repeat (5) @(posedge sys_clk);
        ext_req <= 1'b0;
        `CHK("ext allowed", 1'b1, req_cnt > 1)
        rd(OFS_RST, 32'h1200_0002);
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd(OFS_RST, 32'h1200_0000);
        $display("test causes done");
        // Equal flash divider halves are written in both passes.
        for (int p = 0; p < 2; p++) begin
            for (i = 0; i < 14; i++) begin
                wr(ADR[i], {32{p[0]}});
            end
            for (i = 0; i < 14; i++) begin
                rd(ADR[i], ({32{p[0]}} & MSK[i]) | ADD[i]);
            end
            `CHK("outs", {84{p[0]}}, {depth, clk_ctl, pins, srst, frst, sclk, fclk})
            halted <= 1'b1;
            repeat (5) @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK("halt", {p[0], p[0], {29{p[0]}} & ~HALT_MASK}, {frz_c, frz_d, sclk})
            @(posedge sys_clk);
            halted <= 1'b0;
        end
        for (int m = 0; m < 4; m += m + 1) begin
            wr(OFS_PWR, m);
            // The output follows the register one cycle later.
            @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK("depth", m[1:0], depth)
        end
        $display("test registers done");
        wr(OFS_WRISE, 32'h1);
        wr(OFS_WFALL, 32'h100);
        lines <= 8'h3;
        alarm <= 1'b1;
        repeat (4) @(posedge sys_clk);
        lines <= 8'h0;
        alarm <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rd(OFS_WPEND, 32'h101);
        `CHK("pend out", 9'h101, pend)
        wr(OFS_WPEND, 32'h1);
        rd(OFS_WPEND, 32'h100);
        wr(OFS_WPEND, 32'h100);
        rd(OFS_WPEND, 32'h0);
        $display("test wake done");
        finish_test();
    end
endmodule
